// >>> mac_ctl_pkg.sv
package mac_ctl_pkg;
  // register location in the i/o space
  localparam logic [7:0] MAC_CONTROL_OFFSET  = 8'h50;
  localparam logic [31:0] MAC_CONTROL_RESET  = 32'h0000_0000;
  localparam int unsigned REG_WIDTH          = 32;
  localparam int unsigned DATA_WIDTH         = 8;

  // field positions inside mac_control
  localparam int unsigned KEEP_CHECK_SEQUENCE_BIT   = 9;
  localparam int unsigned BUFFER_WRAP_MODE_BIT      = 10;
  localparam int unsigned MEDIA_SIDE_WRAP_MODE_BIT  = 11;
  localparam int unsigned COLLISION_LIVE_BIT        = 16;
  localparam int unsigned CARRIER_LIVE_BIT          = 17;
  localparam int unsigned TRANSMIT_ACTIVE_BIT       = 18;
  localparam int unsigned TRANSMIT_FAULT_BIT        = 19;
  localparam int unsigned COUNTERS_START_STROBE_BIT = 21;
  localparam int unsigned COUNTERS_STOP_STROBE_BIT  = 22;
  localparam int unsigned COUNTERS_RUNNING_BIT      = 23;
  localparam int unsigned TRANSMIT_ON_STROBE_BIT    = 24;
  localparam int unsigned TRANSMIT_OFF_STROBE_BIT   = 25;
  localparam int unsigned TRANSMIT_ON_STATUS_BIT    = 26;
  localparam int unsigned RECEIVE_ON_STROBE_BIT     = 27;
  localparam int unsigned RECEIVE_OFF_STROBE_BIT    = 28;
  localparam int unsigned RECEIVE_ON_STATUS_BIT     = 29;
  localparam int unsigned PAUSED_BIT                = 30;

  // pin synchroniser depth
  localparam int unsigned SYNC_STAGES = 3;

  // receive buffer write source
  typedef enum logic [1:0] {
    SRC_MEDIA,
    SRC_BUFFER_WRAP,
    SRC_MEDIA_WRAP
  } rx_source_t;
endpackage

// >>> mac_control_upper_fields.sv
`timescale 1ns/10ps
// Overview of operation
// - bit 9 set passes received check sequence bytes into the receive buffer.
// - check sequence errors are always reported, whatever bit 9 holds.
// - system reset clears bit 9.
// - bit 10 set feeds transmit buffer data straight into the receive buffer.
// - bit 11 set, with bit 10 clear, loops transmit data back at the media controller output.
// - bit 16 reads the collision input.
// - bit 17 reads the carrier input.
// - bit 18 reads one while a frame is being transmitted.
// - a transmit starvation event sets bit 19.
// - writing one to bit 21 starts statistics counting, bit self-clears.
// - writing one to bit 22 stops counting, counters hold, bit self-clears.
// - bit 23 reads one while statistics counting runs.
// - bits 24 and 25 are self-clearing transmitter on and off strobes.
// - bit 26 reads one while the transmitter is enabled.
// - bits 27 and 28 are self-clearing receiver on and off strobes.
// - bit 29 reads one while the receiver is enabled.
// - bit 30 reads one while a pause frame holds off transmission.
module mac_control_upper_fields (
  // clock and reset
  input  wire logic                              clk,
  input  wire logic                              srst,
  // register port
  input  wire logic [7:0]                        ctl_addr,
  input  wire logic                              ctl_wr,
  input  wire logic                              ctl_rd,
  input  wire logic [mac_ctl_pkg::REG_WIDTH-1:0] ctl_wdata,
  output logic      [mac_ctl_pkg::REG_WIDTH-1:0] ctl_rdata,
  // media pins, asynchronous
  input  wire logic                              collision_pin,
  input  wire logic                              carrier_pin,
  // transmit and pause state from the mac core
  input  wire logic                              transmit_active_in,
  input  wire logic                              transmit_starvation,
  input  wire logic                              pause_hold_in,
  input  wire logic                              transmit_path_reset,
  input  wire logic                              receive_path_reset,
  // frame check result from the receive mac
  input  wire logic                              rx_check_done,
  input  wire logic                              rx_check_bad,
  // received mac bytes
  input  wire logic [mac_ctl_pkg::DATA_WIDTH-1:0] mac_rx_data,
  input  wire logic                              mac_rx_valid,
  input  wire logic                              mac_rx_fcs,
  // transmit buffer bytes and mac output bytes
  input  wire logic [mac_ctl_pkg::DATA_WIDTH-1:0] txbuf_data,
  input  wire logic                              txbuf_valid,
  input  wire logic [mac_ctl_pkg::DATA_WIDTH-1:0] mac_tx_data,
  input  wire logic                              mac_tx_valid,
  input  wire logic                              mac_tx_fcs,
  // receive buffer write side
  output logic      [mac_ctl_pkg::DATA_WIDTH-1:0] rxbuf_data,
  output logic                                   rxbuf_wr,
  // control levels to the rest of the mac
  output logic                                   buffer_wrap_mode,
  output logic                                   media_side_wrap_mode,
  output logic                                   counters_running,
  output logic                                   transmit_on_status,
  output logic                                   receive_on_status,
  output logic                                   transmit_fault,
  output logic                                   rx_check_error
);
  import mac_ctl_pkg::*;

  // control state
  logic                  keep_check_sequence_q, keep_check_sequence_d;
  logic                  buffer_wrap_mode_q, buffer_wrap_mode_d;
  logic                  media_side_wrap_mode_q, media_side_wrap_mode_d;
  logic                  counters_running_q, counters_running_d;
  logic                  transmit_on_status_q, transmit_on_status_d;
  logic                  receive_on_status_q, receive_on_status_d;
  logic                  transmit_fault_q, transmit_fault_d;
  logic                  rx_check_error_q, rx_check_error_d;
  logic [REG_WIDTH-1:0]  ctl_rdata_q, ctl_rdata_d;
  // pin synchronisers
  logic [SYNC_STAGES-1:0] col_sync_q, col_sync_d;
  logic [SYNC_STAGES-1:0] crs_sync_q, crs_sync_d;
  logic                   collision_live_q, collision_live_d;
  logic                   carrier_live_q, carrier_live_d;
  // receive buffer write path
  logic [DATA_WIDTH-1:0] rxbuf_data_q, rxbuf_data_d;
  logic                  rxbuf_wr_q, rxbuf_wr_d;
  rx_source_t            src;
  logic                  hit, wr_hit, rd_hit;
  logic [REG_WIDTH-1:0]  view;

  // address decode
  always_comb
  begin
    hit = 1'b0;
    if (ctl_addr == MAC_CONTROL_OFFSET)
    begin
      hit = 1'b1;
    end
    wr_hit = ctl_wr & hit;
    rd_hit = ctl_rd & hit;
  end

  // three stage pin capture, change taken when stages two and three agree
  always_comb
  begin
    col_sync_d       = {col_sync_q[SYNC_STAGES-2:0], collision_pin};
    crs_sync_d       = {crs_sync_q[SYNC_STAGES-2:0], carrier_pin};
    collision_live_d = collision_live_q;
    carrier_live_d   = carrier_live_q;
    if (col_sync_q[1] == col_sync_q[2])
    begin
      collision_live_d = col_sync_q[2];
    end
    if (crs_sync_q[1] == crs_sync_q[2])
    begin
      carrier_live_d = crs_sync_q[2];
    end
  end

  // next values of the control and status fields
  always_comb
  begin
    keep_check_sequence_d  = keep_check_sequence_q;
    buffer_wrap_mode_d     = buffer_wrap_mode_q;
    media_side_wrap_mode_d = media_side_wrap_mode_q;
    counters_running_d     = counters_running_q;
    transmit_on_status_d   = transmit_on_status_q;
    receive_on_status_d    = receive_on_status_q;
    transmit_fault_d       = transmit_fault_q;
    if (wr_hit)
    begin
      keep_check_sequence_d  = ctl_wdata[KEEP_CHECK_SEQUENCE_BIT];
      buffer_wrap_mode_d     = ctl_wdata[BUFFER_WRAP_MODE_BIT];
      media_side_wrap_mode_d = ctl_wdata[MEDIA_SIDE_WRAP_MODE_BIT];
      // strobes act only on the write; off is checked last so it wins
      if (ctl_wdata[COUNTERS_START_STROBE_BIT])
      begin
        counters_running_d = 1'b1;
      end
      if (ctl_wdata[COUNTERS_STOP_STROBE_BIT])
      begin
        counters_running_d = 1'b0;
      end
      if (ctl_wdata[TRANSMIT_ON_STROBE_BIT])
      begin
        transmit_on_status_d = 1'b1;
      end
      if (ctl_wdata[TRANSMIT_OFF_STROBE_BIT])
      begin
        transmit_on_status_d = 1'b0;
      end
      if (ctl_wdata[RECEIVE_ON_STROBE_BIT])
      begin
        receive_on_status_d = 1'b1;
      end
      if (ctl_wdata[RECEIVE_OFF_STROBE_BIT])
      begin
        receive_on_status_d = 1'b0;
      end
    end
    // fault held until transmit reset; a new starvation wins the same cycle
    if (transmit_path_reset)
    begin
      transmit_fault_d = 1'b0;
    end
    if (transmit_starvation)
    begin
      transmit_fault_d = 1'b1;
    end
    // check errors reported regardless of pass-through
    rx_check_error_d = rx_check_done & rx_check_bad;
  end

  // register read view; strobe and reserved bits read zero
  always_comb
  begin
    view                            = '0;
    view[KEEP_CHECK_SEQUENCE_BIT]   = keep_check_sequence_q;
    view[BUFFER_WRAP_MODE_BIT]      = buffer_wrap_mode_q;
    view[MEDIA_SIDE_WRAP_MODE_BIT]  = media_side_wrap_mode_q;
    view[COLLISION_LIVE_BIT]        = collision_live_q;
    view[CARRIER_LIVE_BIT]          = carrier_live_q;
    view[TRANSMIT_ACTIVE_BIT]       = transmit_active_in;
    view[TRANSMIT_FAULT_BIT]        = transmit_fault_q;
    view[COUNTERS_RUNNING_BIT]      = counters_running_q;
    view[TRANSMIT_ON_STATUS_BIT]    = transmit_on_status_q;
    view[RECEIVE_ON_STATUS_BIT]     = receive_on_status_q;
    view[PAUSED_BIT]                = pause_hold_in;
    ctl_rdata_d                     = '0;
    if (rd_hit)
    begin
      ctl_rdata_d = view;
    end
  end

  // receive buffer source select and check sequence filter
  always_comb
  begin
    src = SRC_MEDIA;
    if (buffer_wrap_mode_q)
    begin
      src = SRC_BUFFER_WRAP;
    end
    else if (media_side_wrap_mode_q)
    begin
      src = SRC_MEDIA_WRAP;
    end
    rxbuf_data_d = '0;
    rxbuf_wr_d   = 1'b0;
    case (src)
      SRC_BUFFER_WRAP:
      begin
        rxbuf_data_d = txbuf_data;
        rxbuf_wr_d   = txbuf_valid;
      end
      SRC_MEDIA_WRAP:
      begin
        rxbuf_data_d = mac_tx_data;
        rxbuf_wr_d   = mac_tx_valid & (keep_check_sequence_q | ~mac_tx_fcs);
      end
      default:
      begin
        rxbuf_data_d = mac_rx_data;
        rxbuf_wr_d   = mac_rx_valid & (keep_check_sequence_q | ~mac_rx_fcs);
      end
    endcase
    if (~receive_on_status_q | receive_path_reset)
    begin
      rxbuf_wr_d = 1'b0;
    end
  end

  // pin synchroniser registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      col_sync_q       <= '0;
      crs_sync_q       <= '0;
      collision_live_q <= 1'b0;
      carrier_live_q   <= 1'b0;
    end
    else
    begin
      col_sync_q       <= col_sync_d;
      crs_sync_q       <= crs_sync_d;
      collision_live_q <= collision_live_d;
      carrier_live_q   <= carrier_live_d;
    end
  end

  // control and status field registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      keep_check_sequence_q  <= MAC_CONTROL_RESET[KEEP_CHECK_SEQUENCE_BIT];
      buffer_wrap_mode_q     <= MAC_CONTROL_RESET[BUFFER_WRAP_MODE_BIT];
      media_side_wrap_mode_q <= MAC_CONTROL_RESET[MEDIA_SIDE_WRAP_MODE_BIT];
      counters_running_q     <= MAC_CONTROL_RESET[COUNTERS_RUNNING_BIT];
      transmit_on_status_q   <= MAC_CONTROL_RESET[TRANSMIT_ON_STATUS_BIT];
      receive_on_status_q    <= MAC_CONTROL_RESET[RECEIVE_ON_STATUS_BIT];
      transmit_fault_q       <= MAC_CONTROL_RESET[TRANSMIT_FAULT_BIT];
      rx_check_error_q       <= 1'b0;
    end
    else
    begin
      keep_check_sequence_q  <= keep_check_sequence_d;
      buffer_wrap_mode_q     <= buffer_wrap_mode_d;
      media_side_wrap_mode_q <= media_side_wrap_mode_d;
      counters_running_q     <= counters_running_d;
      transmit_on_status_q   <= transmit_on_status_d;
      receive_on_status_q    <= receive_on_status_d;
      transmit_fault_q       <= transmit_fault_d;
      rx_check_error_q       <= rx_check_error_d;
    end
  end

  // read data register, zero between reads
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctl_rdata_q <= '0;
    end
    else
    begin
      ctl_rdata_q <= ctl_rdata_d;
    end
  end

  // receive buffer write registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rxbuf_data_q <= '0;
      rxbuf_wr_q   <= 1'b0;
    end
    else
    begin
      rxbuf_data_q <= rxbuf_data_d;
      rxbuf_wr_q   <= rxbuf_wr_d;
    end
  end

  // outputs straight from flops
  assign ctl_rdata            = ctl_rdata_q;
  assign rxbuf_data           = rxbuf_data_q;
  assign rxbuf_wr             = rxbuf_wr_q;
  assign buffer_wrap_mode     = buffer_wrap_mode_q;
  assign media_side_wrap_mode = media_side_wrap_mode_q;
  assign counters_running     = counters_running_q;
  assign transmit_on_status   = transmit_on_status_q;
  assign receive_on_status    = receive_on_status_q;
  assign transmit_fault       = transmit_fault_q;
  assign rx_check_error       = rx_check_error_q;
endmodule

// >>> mac_ctl_checker.sv
`timescale 1ns/10ps
module mac_ctl_checker
  import mac_ctl_pkg::*;
(
  // clock and reset
  input logic                 clk,
  input logic                 srst,
  // register port
  input logic                 ctl_wr,
  input logic                 ctl_rd,
  input logic [7:0]           ctl_addr,
  input logic [REG_WIDTH-1:0] ctl_wdata,
  input logic [REG_WIDTH-1:0] ctl_rdata,
  // core side inputs
  input logic                 transmit_active_in,
  input logic                 transmit_starvation,
  input logic                 pause_hold_in,
  input logic                 transmit_path_reset,
  input logic                 receive_path_reset,
  input logic                 rx_check_done,
  input logic                 rx_check_bad,
  // watched outputs
  input logic                 rxbuf_wr,
  input logic                 buffer_wrap_mode,
  input logic                 media_side_wrap_mode,
  input logic                 counters_running,
  input logic                 transmit_on_status,
  input logic                 receive_on_status,
  input logic                 transmit_fault,
  input logic                 rx_check_error
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // decoded register hits
  logic hit_w, hit_r;
  assign hit_w = ctl_wr && ctl_addr == MAC_CONTROL_OFFSET;
  assign hit_r = ctl_rd && ctl_addr == MAC_CONTROL_OFFSET;
  AST_TX_ON: assert property (hit_w && ctl_wdata[24] && !ctl_wdata[25] |=> transmit_on_status)
    else $error("transmitter not enabled by its on strobe");
  AST_TX_OFF: assert property (hit_w && ctl_wdata[25] |=> !transmit_on_status)
    else $error("transmitter off strobe did not win");
  AST_RX_SET: assert property (hit_w && (ctl_wdata[27] || ctl_wdata[28]) |=>
    receive_on_status != $past(ctl_wdata[28]))
    else $error("receiver enable state wrong after strobe");
  AST_CNT_SET: assert property (hit_w && (ctl_wdata[21] || ctl_wdata[22]) |=>
    counters_running != $past(ctl_wdata[22]))
    else $error("statistics running state wrong after strobe");
  AST_WRAP: assert property (hit_w |=>
    {media_side_wrap_mode, buffer_wrap_mode} == $past(ctl_wdata[11:10]))
    else $error("wrap mode levels differ from written bits");
  AST_HOLD: assert property (!hit_w |=>
    $stable({counters_running, transmit_on_status, receive_on_status, buffer_wrap_mode}))
    else $error("control level moved without a write");
  AST_FAULT_SET: assert property (transmit_starvation |=> transmit_fault)
    else $error("starvation did not raise transmit fault");
  AST_FAULT_KEEP: assert property (transmit_fault && !transmit_path_reset |=> transmit_fault)
    else $error("transmit fault dropped without path reset");
  AST_FAULT_CLR: assert property (transmit_path_reset && !transmit_starvation |=> !transmit_fault)
    else $error("path reset did not clear transmit fault");
  AST_RD_VIEW: assert property (hit_r |=> (ctl_rdata[30:16] & 15'h648C) == {$past(pause_hold_in),
    $past(receive_on_status), 2'h0, $past(transmit_on_status), 2'h0, $past(counters_running), 3'h0,
    $past(transmit_fault), $past(transmit_active_in), 2'h0}) else $error("status bits read wrong");
  AST_RD_ZERO: assert property (hit_r |=> (ctl_rdata & 32'h9B70_F1FF) == 32'h0)
    else $error("strobe or reserved bit read nonzero");
  AST_RD_MISS: assert property (!hit_r |=> ctl_rdata == 32'h0)
    else $error("read data nonzero without a read");
  AST_CHECK: assert property (rx_check_done && rx_check_bad |=> rx_check_error)
    else $error("check error not reported");
  AST_NO_RX: assert property (!receive_on_status || receive_path_reset |=> !rxbuf_wr)
    else $error("receive buffer written while receive blocked");
  // main scenario coverage
  COV_FAULT: cover property (transmit_starvation ##1 transmit_fault);
  COV_WRAP: cover property (buffer_wrap_mode && rxbuf_wr);
  COV_MEDIA: cover property (media_side_wrap_mode && rxbuf_wr);
endmodule
bind mac_control_upper_fields mac_ctl_checker i_chk (.clk, .srst, .ctl_wr, .ctl_rd, .ctl_addr, .ctl_wdata,
  .ctl_rdata, .transmit_active_in, .transmit_starvation, .pause_hold_in, .transmit_path_reset,
  .receive_path_reset, .rx_check_done, .rx_check_bad, .rxbuf_wr, .buffer_wrap_mode, .media_side_wrap_mode,
  .counters_running, .transmit_on_status, .receive_on_status, .transmit_fault, .rx_check_error);

// >>> mac_control_upper_fields_tb.sv
`timescale 1ns/10ps
module mac_control_upper_fields_tb
  import mac_ctl_pkg::*;
;
  logic        clk, srst, ctl_wr, ctl_rd, collision_pin, carrier_pin, transmit_active_in, rp, ce;
  logic        transmit_starvation, pause_hold_in, transmit_path_reset, receive_path_reset;
  logic        rx_check_done, rx_check_bad, mac_rx_valid, mac_rx_fcs, txbuf_valid, mac_tx_valid, mac_tx_fcs;
  logic        rxbuf_wr, buffer_wrap_mode, media_side_wrap_mode, counters_running;
  logic        transmit_on_status, receive_on_status, transmit_fault, rx_check_error;
  logic [7:0]  ctl_addr, mac_rx_data, txbuf_data, mac_tx_data, rxbuf_data;
  logic [31:0] ctl_wdata, ctl_rdata, vw, seed, rnd, rq[$], bq[$];
  logic [31:0] modes[6] = '{32'h0, 32'h200, 32'h400, 32'h800, 32'hA00, 32'h600};
  int          n_mismatch, checked;
  mac_control_upper_fields i_dut (.clk, .srst, .ctl_addr, .ctl_wr, .ctl_rd, .ctl_wdata, .ctl_rdata,
    .collision_pin, .carrier_pin, .transmit_active_in, .transmit_starvation, .pause_hold_in,
    .transmit_path_reset, .receive_path_reset, .rx_check_done, .rx_check_bad, .mac_rx_data, .mac_rx_valid,
    .mac_rx_fcs, .txbuf_data, .txbuf_valid, .mac_tx_data, .mac_tx_valid, .mac_tx_fcs, .rxbuf_data, .rxbuf_wr,
    .buffer_wrap_mode, .media_side_wrap_mode, .counters_running, .transmit_on_status, .receive_on_status,
    .transmit_fault, .rx_check_error);
  // clock, 100 ns period
  initial
  begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one step past the next rising edge
  task cyc();
    @(posedge clk);
    #1;
  endtask
  task put(input logic [30:0] v);
    {rx_check_bad, rx_check_done, mac_tx_fcs, mac_tx_valid, mac_tx_data, txbuf_valid, txbuf_data,
     mac_rx_fcs, mac_rx_valid, mac_rx_data} = v;
  endtask
  // register write, shadow view updated alongside
  task wr(input logic [7:0] a, input logic [31:0] d);
    cyc();
    {ctl_wr, ctl_addr, ctl_wdata} = {1'b1, a, d};
    if (a == MAC_CONTROL_OFFSET)
    begin
      vw[11:9] = d[11:9];
      for (int k = 21; k < 28; k += 3)
        vw[k+2] = d[k+1] ? 1'b0 : (d[k] | vw[k+2]);
    end
    cyc();
    ctl_wr = 0;
  endtask
  // register read, expectation queued for the monitor
  task rd(input logic [7:0] a);
    logic [31:0] e;
    cyc();
    {ctl_rd, ctl_addr} = {1'b1, a};
    e = vw;
    {e[30], e[18:16]} = {pause_hold_in, transmit_active_in, carrier_pin, collision_pin};
    rq.push_back(a == MAC_CONTROL_OFFSET ? e : 32'h0);
    cyc();
    ctl_rd = 0;
  endtask
  // mode change with receiver off, then both path resets
  task setup(input logic [31:0] m);
    wr(MAC_CONTROL_OFFSET, {20'h0, vw[11:9], 9'h0} | 32'h1000_0000);
    wr(MAC_CONTROL_OFFSET, m | 32'h1000_0000);
    transmit_active_in = 0;
    {transmit_path_reset, receive_path_reset} = 2'b11;
    cyc();
    {transmit_path_reset, receive_path_reset, vw[19]} = 3'b000;
    wr(MAC_CONTROL_OFFSET, m | 32'h0800_0000);
  endtask
  // random byte streams on all three sources
  task stream(input logic prst);
    logic ok;
    receive_path_reset = prst;
    repeat (40)
    begin
      cyc();
      rnd = xs();
      put(rnd[30:0]);
      ok = vw[29] && !prst;
      if (ok && vw[10] && txbuf_valid) bq.push_back({24'h0, txbuf_data});
      if (ok && vw[11:10] == 2'b10 && mac_tx_valid && (!mac_tx_fcs || vw[9])) bq.push_back({24'h0, mac_tx_data});
      if (ok && vw[11:10] == 2'b00 && mac_rx_valid && (!mac_rx_fcs || vw[9])) bq.push_back({24'h0, mac_rx_data});
    end
    cyc();
    put(31'h0);
    receive_path_reset = 0;
  endtask
  // result monitor
  always @(posedge clk)
  begin
    if (rp) chk(ctl_rdata, rq.pop_front());
    if (rxbuf_wr === 1'b1) chk({24'h0, rxbuf_data}, bq.size() ? bq.pop_front() : 32'hDEAD_BEEF);
    if (!srst) chk({31'h0, rx_check_error}, {31'h0, ce});
    ce <= rx_check_done & rx_check_bad;
    rp <= ctl_rd;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end
  initial
  begin
    {ctl_wr, ctl_rd, ctl_addr, ctl_wdata, collision_pin, carrier_pin, transmit_active_in, rp} = '0;
    {transmit_starvation, pause_hold_in, transmit_path_reset, receive_path_reset, vw} = '0;
    put(31'h0);
    seed = 32'h98B4_31D4;
    srst = 1;
    repeat (20) @(posedge clk);
    #1 srst = 0;
    rd(MAC_CONTROL_OFFSET);
    rd(8'h54);
    wr(MAC_CONTROL_OFFSET, 32'h0920_0E00);
    wr(8'h54, 32'hFFFF_FFFF);
    rd(MAC_CONTROL_OFFSET);
    wr(MAC_CONTROL_OFFSET, 32'h1B60_0000);
    rd(MAC_CONTROL_OFFSET);
    // starvation sets fault, only path reset clears, set wins when both
    {transmit_starvation, vw[19]} = 2'b11;
    cyc();
    transmit_starvation = 0;
    rd(MAC_CONTROL_OFFSET);
    rd(MAC_CONTROL_OFFSET);
    {transmit_path_reset, vw[19]} = 2'b10;
    cyc();
    {transmit_path_reset, transmit_starvation, vw[19]} = 3'b011;
    rd(MAC_CONTROL_OFFSET);
    {transmit_path_reset, transmit_starvation, vw[19]} = 3'b111;
    cyc();
    {transmit_path_reset, transmit_starvation} = 2'b00;
    rd(MAC_CONTROL_OFFSET);
    // live pin and core status bits
    repeat (4)
    begin
      rnd = xs();
      {collision_pin, carrier_pin, transmit_active_in, pause_hold_in} = rnd[3:0];
      repeat (6) cyc();
      rd(MAC_CONTROL_OFFSET);
    end
    for (int i = 0; i < 6; i++)
    begin
      setup(modes[i]);
      stream(0);
      rd(MAC_CONTROL_OFFSET);
    end
    wr(MAC_CONTROL_OFFSET, 32'h1000_0600);
    stream(0);
    setup(32'h0);
    stream(1);
    // second reset in mid-run clears every field
    wr(MAC_CONTROL_OFFSET, 32'h0920_0E00);
    srst = 1;
    repeat (2) cyc();
    {srst, vw} = '0;
    repeat (6) cyc();
    rd(MAC_CONTROL_OFFSET);
    repeat (3) cyc();
    chk(bq.size(), 32'h0);
    tally_and_finish();
  end
endmodule
